// file: bench/acs_filter_model.sv
// behavioural model of the modulator and filter that feed the sequencer
// assumes the analog controls come registered from the sequencer on i_clk
`timescale 1ns/1ps
module acs_filter_model (
	// clock
	input wire logic i_clk,
	// analog controls
	input wire logic i_run,
	input wire logic i_swap,
	input wire logic i_grounded,
	input wire logic i_neg_pin,
	input wire logic [2:0] i_channel,
	// filter output
	output logic signed [15:0] o_value
);
	// channel signal plus a fixed front-end offset
	localparam int SIG = 256;
	localparam int OFS = 16;
	logic [15:0] junk_q = 16'hA5C3;
	int sig;
	always_comb sig = SIG + 16 * int'(i_channel);
	always @(posedge i_clk) begin
		junk_q <= ~junk_q + 16'h0001;
		// idle filter output is garbage that changes every cycle
		if (!i_run)
			o_value <= junk_q;
		else if (i_grounded || i_neg_pin)
			o_value <= 16'(OFS);
		else if (i_swap)
			o_value <= 16'(OFS - sig);
		else
			o_value <= 16'(OFS + sig);
	end
endmodule // acs_filter_model

// file: bench/test_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
// assumes the filter model stands in for modulator and filter
`timescale 1ns/1ps
`define CHK(nm, e, g) total_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end
module test_adc_conversion_sequencer
	import acs_pkg::*;
;
	// ratio 64, divider exponent 0
	localparam int P = 64 * 2;
	localparam logic [3:0] CAL_M [3] = '{MODE_CAL_INT, MODE_CAL_AMP, MODE_CAL_SYS};
	localparam logic [31:0] CAL_E [3] = '{32'h0000_0030, 32'h0000_0030, 32'h0000_0360};
	logic i_clk = 1'b0, i_reset = 1'b1, mux = 1'b0, swap_d = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid, ready_n, run, swap, amp_off, unity, gnd, negp;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] chan;
	logic signed [15:0] fval;
	int bad_count = 0, total_checks = 0, swaps = 0;

	acs_sequencer u_acs_sequencer (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_filter_value(fval),
		.i_mux_switched(mux), .o_result_ready_n(ready_n), .o_modulator_run(run),
		.o_input_swap_mode(swap), .o_first_stage_amp_off(amp_off),
		.o_second_stage_unity(unity), .o_inputs_grounded(gnd), .o_neg_pin_to_amp(negp),
		.o_input_channel_select(chan));
	acs_filter_model u_acs_filter_model (.i_clk(i_clk), .i_run(run), .i_swap(swap),
		.i_grounded(gnd && amp_off && unity), .i_neg_pin(negp), .i_channel(chan),
		.o_value(fval));

	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		swap_d <= swap;
		if (swap && !swap_d)
			swaps++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		if (bvalid !== 1'b1)
			bad_count++;
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		if (rvalid !== 1'b1)
			bad_count++;
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(nm, e, d)
		`CHK(nm, RESP_OKAY, r)
	endtask
	task automatic start(input logic [3:0] m, input logic [2:0] ch);
		logic [1:0] r;
		wr(REG_CTRL, 32'h0000_3000 | {25'h0, ch, m}, r);
		`CHK("ctrl resp", RESP_OKAY, r)
		// ready flag rises one edge after the write answer
		@(posedge i_clk);
	endtask
	task automatic wait_lvl(input logic v, output int n);
		n = 0;
		while (ready_n !== v && n < 20000) begin
			@(posedge i_clk);
			n++;
		end
		if (ready_n !== v)
			bad_count++;
	endtask
	// cycles from the mode write to the falling ready flag
	task automatic first(input string nm, input int t);
		int n;
		wait_lvl(1'b0, n);
		`CHK(nm, 1'b1, n >= t - 4 && n <= t + 6)
	endtask
	task automatic pulse();
		mux <= 1'b1;
		repeat (4) @(posedge i_clk);
		mux <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int n1, n2;
		repeat (10) @(posedge i_clk);
		i_reset <= 1'b0;
		rchk("ctrl reset", REG_CTRL, CTRL_RESET);
		rchk("status reset", REG_STATUS, 32'h0000_0001);
		rd(8'h10, d, r);
		`CHK("unmapped read", RESP_SLVERR, r)
		wr(REG_RESULT, 32'h0000_0055, r);
		`CHK("ro write", RESP_SLVERR, r)
		$display("test registers done");
		start(MODE_SINGLE_SWAP, 3'h0);
		first("input_swap_mode single time", SETUP_CYC + 6 * P + CORR_CYC);
		rchk("input_swap_mode single data", REG_RESULT, 32'h0000_0300);
		`CHK("swap seen", 1'b1, swaps > 0)
		rchk("input_swap_mode single mode", REG_CTRL, 32'h0000_3000);
		$display("test chopped single done");
		for (int i = 0; i < 3; i++) begin
			start(CAL_M[i], i == 2 ? 3'h1 : 3'h0);
			first("cal time", SETUP_CYC + 3 * P + 1);
			rchk("cal offset", REG_OFFSET, CAL_E[i]);
			rchk("cal mode", REG_CTRL, i == 2 ? 32'h0000_3010 : 32'h0000_3000);
		end
		$display("test calibration done");
		wr(REG_OFFSET, 32'h0000_0030, r);
		`CHK("offset resp", RESP_OKAY, r)
		rchk("offset write", REG_OFFSET, 32'h0000_0030);
		start(MODE_SINGLE, 3'h0);
		fork
			pulse();
		join_none
		first("single time", SETUP_CYC + 3 * P + CORR_CYC);
		rchk("single data", REG_RESULT, 32'h0000_0300);
		rchk("single mode", REG_CTRL, 32'h0000_3000);
		$display("test single done");
		start(MODE_CONT, 3'h0);
		first("cont first", SETUP_CYC + 3 * P + CORR_CYC);
		wait_lvl(1'b1, n1);
		wait_lvl(1'b0, n2);
		`CHK("cont period", P, n1 + n2)
		`CHK("cont correction", CORR_CYC, n2)
		rchk("cont data", REG_RESULT, 32'h0000_0300);
		rchk("cont mode", REG_CTRL, 32'h0000_3003);
		fork
			pulse();
		join_none
		wait_lvl(1'b1, n1);
		wait_lvl(1'b0, n2);
		`CHK("mux rewait", 1'b1, n1 + n2 >= SETUP_CYC + 3 * P && n1 + n2 <= SETUP_CYC + 3 * P + 60)
		start(MODE_IDLE, 3'h0);
		repeat (2 * P) @(posedge i_clk);
		rchk("cont stopped", REG_STATUS, 32'h0000_0001);
		$display("test continuous done");
		start(MODE_CONT_SWAP, 3'h0);
		first("input_swap_mode cont first", SETUP_CYC + 6 * P + CORR_CYC);
		wait_lvl(1'b1, n1);
		wait_lvl(1'b0, n2);
		`CHK("input_swap_mode cont period", 3 * P, n1 + n2)
		rchk("input_swap_mode cont data", REG_RESULT, 32'h0000_02D0);
		start(MODE_IDLE, 3'h0);
		$display("test chopped continuous done");
		report_and_stop();
	end

	initial begin
		repeat (60000) @(posedge i_clk);
		bad_count++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule // test_adc_conversion_sequencer

// file: hdl/acs_period_timer.sv
// base conversion period timer: one tick per oversampling_ratio modulator clocks
// assumes the modulator clock is i_clk divided by two to the divider exponent plus one
`timescale 1ns/1ps
module acs_period_timer
	import acs_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// control
	input wire logic i_run,
	input wire logic [1:0] i_osr_sel,
	input wire logic [1:0] i_clock_divider_exponent,
	// tick
	output logic o_tick
);

	logic [13:0] count_q;
	logic [13:0] period_w;
	logic [2:0] shift_w;

	// osr select 0..3 means 512, 256, 128, 64
	assign shift_w = 3'h3 - {1'b0, i_osr_sel} + {1'b0, i_clock_divider_exponent} + 3'h1;
	assign period_w = OSR_MIN << shift_w;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			count_q <= 14'h0000;
			o_tick <= 1'b0;
		end else if (i_ce) begin
			if (!i_run) begin
				count_q <= 14'h0000;
				o_tick <= 1'b0;
			end else if (count_q == period_w - 14'h0001) begin
				count_q <= 14'h0000;
				o_tick <= 1'b1;
			end else begin
				count_q <= count_q + 14'h0001;
				o_tick <= 1'b0;
			end
		end
	end

endmodule // acs_period_timer

// file: hdl/acs_pkg.sv
// constants, types and helpers for the conversion sequencer
// assumes i_clk is the oscillator clock at 250 MHz
package acs_pkg;

	// timing
	localparam int CLK_MHZ = 250;
	localparam int SETUP_DELAY_NS = 10000;
	localparam int SETUP_CYC = (SETUP_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int CORR_OSC_CYC = 40;
	localparam int CORR_CYC = CORR_OSC_CYC;
	localparam logic [13:0] OSR_MIN = 14'h0040;

	// operating modes
	localparam logic [3:0] MODE_IDLE = 4'h0;
	localparam logic [3:0] MODE_SINGLE = 4'h2;
	localparam logic [3:0] MODE_CONT = 4'h3;
	localparam logic [3:0] MODE_SINGLE_SWAP = 4'h4;
	localparam logic [3:0] MODE_CONT_SWAP = 4'h5;
	localparam logic [3:0] MODE_CAL_INT = 4'h8;
	localparam logic [3:0] MODE_CAL_AMP = 4'hA;
	localparam logic [3:0] MODE_CAL_SYS = 4'hC;

	// register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RESULT = 8'h08;
	localparam logic [7:0] REG_OFFSET = 8'h0C;

	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CHAN_LSB = 4;
	localparam int CTRL_DIV_LSB = 8;
	localparam int CTRL_OSR_LSB = 12;
	localparam int STAT_READY_N_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_SWAP_BIT = 2;

	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [23:0] OFFSET_RESET = 24'h00_0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_CONVERT, ST_FINISH} acs_state_type;

	function automatic logic is_op(input logic [3:0] m);
		return m == MODE_SINGLE || m == MODE_CONT || m == MODE_SINGLE_SWAP
			|| m == MODE_CONT_SWAP || m == MODE_CAL_INT || m == MODE_CAL_AMP
			|| m == MODE_CAL_SYS;
	endfunction

	function automatic logic is_cont(input logic [3:0] m);
		return m == MODE_CONT || m == MODE_CONT_SWAP;
	endfunction

	function automatic logic is_swap(input logic [3:0] m);
		return m == MODE_SINGLE_SWAP || m == MODE_CONT_SWAP;
	endfunction

	function automatic logic is_cal(input logic [3:0] m);
		return m == MODE_CAL_INT || m == MODE_CAL_AMP || m == MODE_CAL_SYS;
	endfunction

endpackage

// file: hdl/acs_sequencer.sv
// conversion and offset calibration sequencer with an axi4-lite register slave
// assumes i_filter_value comes from the digital filter on i_clk, i_mux_switched from a pin
// Function
// - mode 0x2 waits setup, converts three base periods, result sums all three
// - every raw conversion spends the correction time before the result is stored
// - storing a corrected result drives the ready flag from 1 to 0
// - single-shot operations set the mode field back to idle after storing
// - data rate is clock over ratio, over two to divider plus one, over three
// - single conversion needs no extra settling after an input multiplexer change
// - mode 0x4 makes two conversions over six periods into one offset-free result
// - chopped modes swap positive and negative inputs between halves internally
// - continuous mode 0x3 raises ready when each next conversion completes, before storing
// - continuous results overwrite the result register and lower ready until idle written
// - continuous results arrive at three times the single conversion rate
// - multiplexer change in continuous mode restarts the full first-conversion wait
// - mode 0x5 swaps inputs every three periods, one result per three periods
// - every chopped continuous result, the first too, spans six base periods
// - calibration modes wait setup, convert three periods, store offset, ready low, idle
// - internal calibration turns first amplifier off, second to unity, grounds inputs
// - first amplifier calibration ties negative pin to both amplifier inputs
// - system offset calibration measures the channel chosen by the channel select
// - setup time from mode write to conversion start is ten microseconds
// - data correction lasts forty oscillator cycles
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// axi4-lite slave
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// converter side
	input wire logic signed [15:0] i_filter_value,
	input wire logic i_mux_switched,
	// analog control and ready flag
	output logic o_result_ready_n,
	output logic o_modulator_run,
	output logic o_input_swap_mode,
	output logic o_first_stage_amp_off,
	output logic o_second_stage_unity,
	output logic o_inputs_grounded,
	output logic o_neg_pin_to_amp,
	output logic [2:0] o_input_channel_select
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	acs_state_type state_q;
	logic [3:0] mode_q;
	logic [3:0] run_mode_q;
	logic [2:0] chan_q;
	logic [1:0] div_q;
	logic [1:0] osr_q;
	logic [23:0] offset_q;
	logic signed [19:0] result_q;
	logic signed [19:0] raw_q;
	logic restart_q;
	logic [11:0] setup_cnt_q;
	logic [2:0] hv_q;
	logic [1:0] phase_q;
	logic swap_q;
	logic signed [15:0] hist_q [0:4];
	logic corr_busy_q;
	logic [5:0] corr_cnt_q;
	logic stored_once_q;
	logic mux_s1_q;
	logic mux_s2_q;
	logic mux_s3_q;
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic tick_w;
	logic mux_edge_w;
	logic wr_fire_w;
	logic wr_ctrl_w;
	logic wr_offset_w;
	logic [31:0] ctrl_w;
	logic [31:0] ctrl_new_w;
	logic [31:0] offset_new_w;
	logic signed [15:0] contrib_w;
	logic signed [19:0] sum3_w;
	logic signed [19:0] sum6_w;
	logic signed [19:0] raw_w;
	logic emit_w;
	logic cal_store_w;
	logic conv_store_w;
	logic mux_restart_w;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// input multiplexer change pin

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mux_s1_q <= 1'b0;
			mux_s2_q <= 1'b0;
			mux_s3_q <= 1'b0;
		end else if (i_ce) begin
			mux_s1_q <= i_mux_switched;
			mux_s2_q <= mux_s1_q;
			mux_s3_q <= mux_s2_q;
		end
	end

	assign mux_edge_w = mux_s2_q && !mux_s3_q;

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel

	assign wr_fire_w = aw_have_q && w_have_q && !o_s_axi_bvalid;
	assign wr_ctrl_w = wr_fire_w && awaddr_q == REG_CTRL;
	assign wr_offset_w = wr_fire_w && awaddr_q == REG_OFFSET;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= RESP_OKAY;
		end else if (i_ce) begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				awaddr_q <= {i_s_axi_awaddr[7:2], 2'h0};
				aw_have_q <= 1'b1;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				wdata_q <= i_s_axi_wdata;
				wstrb_q <= i_s_axi_wstrb;
				w_have_q <= 1'b1;
				o_s_axi_wready <= 1'b0;
			end
			if (wr_fire_w) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= (wr_ctrl_w || wr_offset_w) ? RESP_OKAY : RESP_SLVERR;
			end
			if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	assign ctrl_w = {18'h0, osr_q, 2'h0, div_q, 1'b0, chan_q, mode_q};

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= RESP_OKAY;
		end else if (i_ce) begin
			if (i_s_axi_arvalid && o_s_axi_arready) begin
				o_s_axi_arready <= 1'b0;
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rresp <= RESP_OKAY;
				unique case ({i_s_axi_araddr[7:2], 2'h0})
					REG_CTRL: o_s_axi_rdata <= ctrl_w;
					REG_STATUS: o_s_axi_rdata <= {29'h0, swap_q, state_q != ST_IDLE,
						o_result_ready_n};
					REG_RESULT: o_s_axi_rdata <= {{12{result_q[19]}}, result_q};
					REG_OFFSET: o_s_axi_rdata <= {{8{offset_q[23]}}, offset_q};
					default: begin
						o_s_axi_rdata <= 32'h0000_0000;
						o_s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
				o_s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register and mode field

	assign ctrl_new_w = merge(ctrl_w, wdata_q, wstrb_q);
	assign offset_new_w = merge({8'h00, offset_q}, wdata_q, wstrb_q);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mode_q <= CTRL_RESET[CTRL_MODE_LSB +: 4];
			chan_q <= CTRL_RESET[CTRL_CHAN_LSB +: 3];
			div_q <= CTRL_RESET[CTRL_DIV_LSB +: 2];
			osr_q <= CTRL_RESET[CTRL_OSR_LSB +: 2];
			restart_q <= 1'b0;
		end else if (i_ce) begin
			restart_q <= wr_ctrl_w;
			if (wr_ctrl_w) begin
				mode_q <= ctrl_new_w[CTRL_MODE_LSB +: 4];
				chan_q <= ctrl_new_w[CTRL_CHAN_LSB +: 3];
				div_q <= ctrl_new_w[CTRL_DIV_LSB +: 2];
				osr_q <= ctrl_new_w[CTRL_OSR_LSB +: 2];
			end else if (cal_store_w || (conv_store_w && !is_cont(run_mode_q))) begin
				mode_q <= MODE_IDLE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencing

	acs_period_timer u_timer (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_run(state_q == ST_CONVERT && !restart_q),
		.i_osr_sel(osr_q),
		.i_clock_divider_exponent(div_q),
		.o_tick(tick_w)
	);

	assign contrib_w = swap_q ? -i_filter_value : i_filter_value;
	assign sum3_w = 20'(contrib_w) + 20'(hist_q[0]) + 20'(hist_q[1]);
	assign sum6_w = sum3_w + 20'(hist_q[2]) + 20'(hist_q[3]) + 20'(hist_q[4]);
	assign raw_w = is_swap(run_mode_q) ? (sum6_w >>> 1) : sum3_w;
	assign mux_restart_w = is_cont(run_mode_q) && mux_edge_w;
	// single modes stop after one result; continuous mode 0x3 emits on every tick from the third, mode 0x5 on every third from the sixth
	assign emit_w = state_q == ST_CONVERT && tick_w && !restart_q && !mux_restart_w
		&& (is_swap(run_mode_q) ? (hv_q >= 3'h5 && phase_q == 2'h2) : hv_q >= 3'h2);
	assign cal_store_w = emit_w && is_cal(run_mode_q);
	assign conv_store_w = corr_busy_q && corr_cnt_q == 6'(CORR_CYC - 1);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_q <= ST_IDLE;
			run_mode_q <= MODE_IDLE;
			setup_cnt_q <= 12'h000;
			hv_q <= 3'h0;
			phase_q <= 2'h0;
			swap_q <= 1'b0;
			for (int i = 0; i < 5; i++) begin
				hist_q[i] <= 16'h0000;
			end
		end else if (i_ce) begin
			if (restart_q || (state_q == ST_CONVERT && mux_restart_w)) begin
				if (restart_q) begin
					run_mode_q <= mode_q;
				end
				state_q <= (restart_q && !is_op(mode_q)) ? ST_IDLE : ST_SETUP;
				setup_cnt_q <= 12'h000;
				hv_q <= 3'h0;
				phase_q <= 2'h0;
				swap_q <= 1'b0;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
					end
					ST_SETUP: begin
						if (setup_cnt_q == 12'(SETUP_CYC - 1)) begin
							state_q <= ST_CONVERT;
						end else begin
							setup_cnt_q <= setup_cnt_q + 12'h001;
						end
					end
					ST_CONVERT: begin
						if (tick_w) begin
							hist_q[0] <= contrib_w;
							for (int i = 1; i < 5; i++) begin
								hist_q[i] <= hist_q[i-1];
							end
							hv_q <= (hv_q == 3'h6) ? hv_q : hv_q + 3'h1;
							phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
							if (is_swap(run_mode_q) && phase_q == 2'h2) begin
								swap_q <= !swap_q;
							end
							if (emit_w && !is_cont(run_mode_q)) begin
								state_q <= ST_FINISH;
							end
						end
					end
					ST_FINISH: begin
						if (!corr_busy_q) begin
							state_q <= ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// correction, result, offset and ready flag

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			corr_busy_q <= 1'b0;
			corr_cnt_q <= 6'h00;
			raw_q <= 20'h00000;
		end else if (i_ce) begin
			if (emit_w && !is_cal(run_mode_q)) begin
				raw_q <= raw_w;
				corr_busy_q <= 1'b1;
				corr_cnt_q <= 6'h00;
			end else if (conv_store_w) begin
				corr_busy_q <= 1'b0;
			end else if (corr_busy_q) begin
				corr_cnt_q <= corr_cnt_q + 6'h01;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			result_q <= 20'h00000;
			offset_q <= OFFSET_RESET;
		end else if (i_ce) begin
			if (conv_store_w) begin
				result_q <= raw_q - offset_q[19:0];
			end
			if (cal_store_w) begin
				offset_q <= {{4{raw_w[19]}}, raw_w};
			end else if (wr_offset_w) begin
				offset_q <= offset_new_w[23:0];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_result_ready_n <= 1'b1;
			stored_once_q <= 1'b0;
		end else if (i_ce) begin
			if (conv_store_w || cal_store_w) begin
				o_result_ready_n <= 1'b0;
				stored_once_q <= 1'b1;
			end else if (restart_q) begin
				o_result_ready_n <= 1'b1;
				stored_once_q <= 1'b0;
			end else if (emit_w && is_cont(run_mode_q) && stored_once_q) begin
				o_result_ready_n <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog path control

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_modulator_run <= 1'b0;
			o_input_swap_mode <= 1'b0;
			o_first_stage_amp_off <= 1'b0;
			o_second_stage_unity <= 1'b0;
			o_inputs_grounded <= 1'b0;
			o_neg_pin_to_amp <= 1'b0;
			o_input_channel_select <= 3'h0;
		end else if (i_ce) begin
			o_modulator_run <= state_q == ST_CONVERT;
			o_input_swap_mode <= swap_q;
			o_first_stage_amp_off <= state_q == ST_CONVERT && run_mode_q == MODE_CAL_INT;
			o_second_stage_unity <= state_q == ST_CONVERT && run_mode_q == MODE_CAL_INT;
			o_inputs_grounded <= state_q == ST_CONVERT && run_mode_q == MODE_CAL_INT;
			o_neg_pin_to_amp <= state_q == ST_CONVERT && run_mode_q == MODE_CAL_AMP;
			o_input_channel_select <= chan_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset || !i_ce);

	sequence s_corr_wait;
		##40 conv_store_w;
	endsequence

	sequence s_ready_low;
		##1 !o_result_ready_n;
	endsequence

	chk_ready_fall_cause: assert property ($fell(o_result_ready_n)
		|-> $past(conv_store_w) || $past(cal_store_w)) else $error("ready fell without store");
	chk_corr_time_len: assert property (emit_w && !is_cal(run_mode_q) |-> s_corr_wait)
		else $error("correction time is not 40 cycles");
	chk_store_ready: assert property (conv_store_w |-> s_ready_low)
		else $error("ready not low after store");
	chk_single_back_idle: assert property (conv_store_w && !is_cont(run_mode_q) && !wr_ctrl_w
		|=> mode_q == MODE_IDLE) else $error("mode not idle after single");
	chk_setup_len_exact: assert property (state_q == ST_CONVERT && $past(state_q) == ST_SETUP
		|-> $past(setup_cnt_q) == 12'(SETUP_CYC - 1)) else $error("setup too short");
	chk_single_three_periods: assert property (emit_w && !is_swap(run_mode_q) && !is_cont(run_mode_q)
		|-> hv_q == 3'h2) else $error("single not three periods");
	chk_swap_six_periods: assert property (emit_w && is_swap(run_mode_q)
		|-> hv_q >= 3'h5 && phase_q == 2'h2) else $error("input_swap_mode result not six periods");
	chk_swap_on_block: assert property ($changed(swap_q) && !$past(restart_q)
		&& !$past(mux_restart_w) |-> $past(tick_w) && $past(phase_q) == 2'h2)
		else $error("swap not on block edge");
	chk_cont_ready_rise: assert property (emit_w && is_cont(run_mode_q) && stored_once_q
		&& !conv_store_w |=> o_result_ready_n) else $error("ready not raised");
	chk_cal_offset_store: assert property (cal_store_w && !restart_q
		|=> offset_q[19:0] == $past(raw_w) && !o_result_ready_n)
		else $error("offset not stored");
	chk_int_cal_path: assert property (state_q == ST_CONVERT && run_mode_q == MODE_CAL_INT
		|=> o_inputs_grounded && o_first_stage_amp_off && o_second_stage_unity)
		else $error("internal calibration path wrong");
	chk_amp_cal_path: assert property (state_q == ST_CONVERT && run_mode_q == MODE_CAL_AMP
		|=> o_neg_pin_to_amp) else $error("negative pin not tied");
	chk_mux_restart: assert property (state_q == ST_CONVERT && mux_restart_w && !restart_q
		|=> state_q == ST_SETUP) else $error("mux change did not restart");

endmodule // acs_sequencer
